// [dalu_top.sv]
// Summary of operation
// - Rising mode alarms on a low-to-high input change, falling mode on high-to-low.
// - Any-edge mode alarms on every input change in either direction.
// - High-level mode alarms while the input is high, low-level while it is low.
// - Each output is driven by up to four selected alarms and is active if any is.
// - Any active unacknowledged alarm makes the beacon flash.
// - Active alarms that are all acknowledged light the beacon steadily.
// - A non-latching alarm acknowledged while present stays steady until it clears.
// - A relay energises on the alarm and stays so until acked and condition gone.
// - A non-latching alarm clears at once when its condition goes, with no ack.
// - Auto latching holds until cleared and acked, and an early ack is recorded.
// - Manual latching holds until cleared and acked, counting only later acks.
// - Eight independent alarm instances each keep their own settings and state.
// - An alarm of type none is disabled and never becomes active.
`timescale 1ns/1ps
`default_nettype none
`include "dalu_params.svh"

module dalu_top #(
	parameter int NUM_ALARMS = `DALU_NUM_ALARMS,
	parameter int NUM_OUTPUTS = `DALU_NUM_OUTPUTS,
	parameter int FLASH_HALF_CYC = `DALU_FLASH_HALF_CYC
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clk_en,
	// Alarm configuration
	input wire dalu_pkg::dalu_cfg_s [NUM_ALARMS-1:0] cfg,
	input wire dalu_pkg::dalu_osel_s [NUM_OUTPUTS-1:0] osel,
	// Monitored pins and operator acknowledge
	input wire logic [NUM_ALARMS-1:0] mon_pin,
	input wire logic [NUM_ALARMS-1:0] ack_pulse,
	// Indication and drive
	output logic alarm_beacon,
	output logic [NUM_OUTPUTS-1:0] out_active,
	output logic [NUM_OUTPUTS-1:0] relay_drive_n,
	output logic [NUM_ALARMS-1:0] alarm_active,
	output logic [NUM_ALARMS-1:0] alarm_acked
);
	import dalu_pkg::*;

	logic [NUM_ALARMS-1:0] sync1_q, sync2_q, sync3_q, mon_q;
	dalu_stat_s [NUM_ALARMS-1:0] stat;
	logic [NUM_ALARMS-1:0] act, ackd, relay_hold;
	logic [NUM_ALARMS-1:0] relay_hold_q;
	logic [`DALU_FLASH_CNT_W-1:0] flash_cnt_q;
	logic flash_q;
	logic any_unack, any_act;
	logic [NUM_OUTPUTS-1:0] out_d, relay_d;

	function automatic logic sel_any(input dalu_osel_s s,
		input logic [NUM_ALARMS-1:0] v);
		logic r;
		r = 1'b0;
		for (int k = 0; k < `DALU_SEL_PER_OUT; k++)
			r = r | (s.sel_en[k] & v[s.sel_idx[k]]);
		return r;
	endfunction : sel_any

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sync1_q <= '0;
			sync2_q <= '0;
			sync3_q <= '0;
			mon_q <= '0;
		end else if (clk_en) begin
			sync1_q <= mon_pin;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			for (int i = 0; i < NUM_ALARMS; i++)
				if (sync2_q[i] == sync3_q[i])
					mon_q[i] <= sync3_q[i];
		end
	end

	// ----------------------------------------
	// Alarm instances
	// ----------------------------------------
	for (genvar g = 0; g < NUM_ALARMS; g++) begin : g_alm
		dalu_inst u_inst (
			.clock(clock),
			.rst_n(rst_n),
			.clk_en(clk_en),
			.cfg(cfg[g]),
			.mon_in(mon_q[g]),
			.ack_pulse(ack_pulse[g]),
			.stat(stat[g])
		);
		assign act[g] = stat[g].active;
		assign ackd[g] = stat[g].acked;
		// Relay stays on until acked and condition gone
		always_ff @(posedge clock) begin
			if (!rst_n) begin
				relay_hold_q[g] <= 1'b0;
			end else if (clk_en) begin
				if (stat[g].cond)
					relay_hold_q[g] <= 1'b1;
				else if (!stat[g].active &&
				         (stat[g].acked || ack_pulse[g]))
					relay_hold_q[g] <= 1'b0;
			end
		end
		assign relay_hold[g] = stat[g].active | relay_hold_q[g];
	end

	// ----------------------------------------
	// Beacon
	// ----------------------------------------
	assign any_unack = |(act & ~ackd);
	assign any_act = |act;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			flash_cnt_q <= '0;
			flash_q <= 1'b0;
		end else if (clk_en) begin
			if (flash_cnt_q == `DALU_FLASH_CNT_W'(FLASH_HALF_CYC - 1)) begin
				flash_cnt_q <= '0;
				flash_q <= ~flash_q;
			end else begin
				flash_cnt_q <= flash_cnt_q + 1'b1;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n)
			alarm_beacon <= 1'b0;
		else if (clk_en) begin
			if (any_unack)
				alarm_beacon <= flash_q;
			else
				alarm_beacon <= any_act;
		end
	end

	// ----------------------------------------
	// Output combining and relays
	// ----------------------------------------
	always_comb begin
		for (int o = 0; o < NUM_OUTPUTS; o++) begin
			out_d[o] = sel_any(osel[o], act);
			relay_d[o] = ~sel_any(osel[o], relay_hold);
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			out_active <= '0;
			relay_drive_n <= '1;
			alarm_active <= '0;
			alarm_acked <= '0;
		end else if (clk_en) begin
			out_active <= out_d;
			relay_drive_n <= relay_d;
			alarm_active <= act;
			alarm_acked <= ackd;
		end
	end

	steady_beacon_a: assert property (@(posedge clock) disable iff (!rst_n)
		(clk_en && any_act && !any_unack) |=> alarm_beacon)
		else $error("acked alarm beacon not steady");

	beacon_off_a: assert property (@(posedge clock) disable iff (!rst_n)
		(clk_en && !any_act) |=> !alarm_beacon)
		else $error("beacon lit with no alarm");

	output_or_a: assert property (@(posedge clock) disable iff (!rst_n)
		clk_en |=> (out_active == $past(out_d)))
		else $error("output combine mismatch");

endmodule : dalu_top

`default_nettype wire

// [dalu_params.svh]
`ifndef DALU_PARAMS_SVH
`define DALU_PARAMS_SVH

// Instance and output counts
`define DALU_NUM_ALARMS 8
`define DALU_NUM_OUTPUTS 8
`define DALU_SEL_PER_OUT 4
`define DALU_SEL_IDX_W 3

// Beacon flash timing
`define DALU_CLK_HZ 10000000
`define DALU_FLASH_HALF_MS 250
`define DALU_FLASH_HALF_CYC ((`DALU_CLK_HZ / 1000) * `DALU_FLASH_HALF_MS)
`define DALU_FLASH_CNT_W 24

`endif

// [dalu_pkg.sv]
package dalu_pkg;

	typedef enum logic [2:0] {
		DALU_TYPE_NONE = 3'h0,
		DALU_TYPE_RISE = 3'h1,
		DALU_TYPE_FALL = 3'h2,
		DALU_TYPE_EDGE = 3'h3,
		DALU_TYPE_HIGH = 3'h4,
		DALU_TYPE_LOW = 3'h5
	} dalu_type_e;

	typedef enum logic [1:0] {
		DALU_LATCH_NONE = 2'h0,
		DALU_LATCH_AUTO = 2'h1,
		DALU_LATCH_MANUAL = 2'h2
	} dalu_latch_e;

	typedef struct packed {
		dalu_type_e alarm_type;
		dalu_latch_e latch_mode;
	} dalu_cfg_s;

	// Alarm selection for one physical output
	typedef struct packed {
		logic [3:0] sel_en;
		logic [3:0][2:0] sel_idx;
	} dalu_osel_s;

	typedef struct packed {
		logic active;
		logic acked;
		logic cond;
	} dalu_stat_s;

endpackage : dalu_pkg

// [dalu_inst.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dalu_params.svh"

module dalu_inst (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clk_en,
	// Configuration
	input wire dalu_pkg::dalu_cfg_s cfg,
	// Monitored input (same domain) and acknowledge pulse
	input wire logic mon_in,
	input wire logic ack_pulse,
	// State
	output dalu_pkg::dalu_stat_s stat
);
	import dalu_pkg::*;

	logic prev_q;
	logic active_q;
	logic acked_q;
	logic cond;
	logic enabled;

	assign enabled = (cfg.alarm_type != DALU_TYPE_NONE);

	// ----------------------------------------
	// Condition detection
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n)
			prev_q <= 1'b0;
		else if (clk_en)
			prev_q <= mon_in;
	end

	always_comb begin
		unique case (cfg.alarm_type)
			DALU_TYPE_RISE: cond = mon_in & ~prev_q;
			DALU_TYPE_FALL: cond = ~mon_in & prev_q;
			DALU_TYPE_EDGE: cond = mon_in ^ prev_q;
			DALU_TYPE_HIGH: cond = mon_in;
			DALU_TYPE_LOW: cond = ~mon_in;
			default: cond = 1'b0;
		endcase
	end

	// ----------------------------------------
	// Active and acknowledge state
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n || !enabled) begin
			active_q <= 1'b0;
		end else if (clk_en) begin
			if (cond)
				active_q <= 1'b1;
			else if (cfg.latch_mode == DALU_LATCH_NONE)
				active_q <= 1'b0;
			else if (acked_q || ack_pulse)
				active_q <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n || !enabled) begin
			acked_q <= 1'b0;
		end else if (clk_en) begin
			if (cond && !active_q)
				acked_q <= 1'b0;
			else if (ack_pulse && active_q &&
			         (cfg.latch_mode != DALU_LATCH_MANUAL || !cond))
				acked_q <= 1'b1;
			else if (!active_q)
				acked_q <= 1'b0;
		end
	end

	assign stat.active = active_q;
	assign stat.acked = acked_q;
	assign stat.cond = cond;

	manual_ack_a: assert property (@(posedge clock) disable iff (!rst_n)
		(clk_en && cond && active_q && !acked_q &&
		 cfg.latch_mode == DALU_LATCH_MANUAL) |=> !acked_q)
		else $error("manual latch took ack while condition present");

	none_type_a: assert property (@(posedge clock) disable iff (!rst_n)
		!enabled |=> !active_q)
		else $error("disabled alarm became active");

	nolatch_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
		(clk_en && enabled && !cond &&
		 cfg.latch_mode == DALU_LATCH_NONE) |=> !active_q)
		else $error("non latching alarm did not clear");

	latch_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
		(clk_en && enabled && active_q && !acked_q && !ack_pulse &&
		 cfg.latch_mode != DALU_LATCH_NONE) |=> active_q)
		else $error("latched alarm cleared without ack");

	rise_det_a: assert property (@(posedge clock) disable iff (!rst_n)
		(clk_en && enabled && cfg.alarm_type == DALU_TYPE_RISE &&
		 mon_in && !prev_q) |=> active_q)
		else $error("rising edge not detected");

endmodule : dalu_inst

`default_nettype wire

// [dalu_operator.sv]
`timescale 1ns/1ps
`default_nettype none
module dalu_operator (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Key presses and acknowledge pulses
	input wire logic [7:0] ack_req,
	output logic [7:0] ack_pulse
);
	logic [7:0] req_q;
	// One pulse per key press, however long the key is held
	always_ff @(posedge clock) begin
		req_q <= rst_n ? ack_req : 8'h00;
		ack_pulse <= rst_n ? (ack_req & ~req_q) : 8'h00;
	end
endmodule : dalu_operator
`default_nettype wire

// [dalu_top_test.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin err_count++; \
	$display("wrong value %s exp %0h got %0h", n, e, s); end end
module dalu_top_test;
	import dalu_pkg::*;
	logic clock, rst_n, alarm_beacon, b_or, b_and, e_b;
	dalu_cfg_s [7:0] cfg;
	dalu_osel_s [7:0] osel;
	logic [7:0] mon_pin, ack_req, ack_pulse, out_active, relay_drive_n;
	logic [7:0] alarm_active, alarm_acked;
	int err_count, cmp_count, cyc;
	dalu_type_e t;
	dalu_top #(.FLASH_HALF_CYC(4)) u_dalu_top (.clock(clock), .rst_n(rst_n),
		.clk_en(1'b1), .cfg(cfg), .osel(osel), .mon_pin(mon_pin),
		.ack_pulse(ack_pulse), .alarm_beacon(alarm_beacon),
		.out_active(out_active), .relay_drive_n(relay_drive_n),
		.alarm_active(alarm_active), .alarm_acked(alarm_acked));
	dalu_operator u_dalu_operator (.clock(clock), .rst_n(rst_n),
		.ack_req(ack_req), .ack_pulse(ack_pulse));
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	task tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : tick
	task pin(input int i, input logic v);
		@(posedge clock);
		mon_pin[i] <= v;
		tick(8);
	endtask : pin
	task ack(input int i);
		@(posedge clock);
		ack_req[i] <= 1'b1;
		repeat (2) @(posedge clock);
		ack_req[i] <= 1'b0;
		tick(4);
	endtask : ack
	task beacon();
		b_or = 1'b0;
		b_and = 1'b1;
		repeat (12) begin
			tick(1);
			b_or = b_or | alarm_beacon;
			b_and = b_and & alarm_beacon;
		end
	endtask : beacon
	task do_rst(input dalu_cfg_s [7:0] c);
		@(posedge clock);
		rst_n <= 1'b0;
		cfg <= c;
		mon_pin <= 8'h00;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		tick(8);
	endtask : do_rst
	task end_of_test();
		$display("checks %0d errors %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_of_test
	always @(posedge clock) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			end_of_test();
		end
	end
	initial begin
		rst_n = 1'b0;
		cfg = '0;
		mon_pin = 8'h00;
		ack_req = 8'h00;
		err_count = 0;
		cmp_count = 0;
		cyc = 0;
		for (int k = 0; k < 8; k++) begin
			osel[k].sel_en = 4'h1;
			osel[k].sel_idx = {9'h000, 3'(k)};
		end
		osel[0].sel_en = 4'hf;
		osel[0].sel_idx = {3'h3, 3'h2, 3'h1, 3'h0};
		// --------------------------------
		// Every type on auto latching
		// --------------------------------
		for (int i = 0; i < 6; i++) begin
			t = dalu_type_e'(i);
			do_rst({30'h0, dalu_cfg_s'{t, DALU_LATCH_AUTO}, 5'h0});
			`CHK("idle", t == DALU_TYPE_LOW, alarm_active[1])
			pin(1, 1'b1);
			e_b = t inside {DALU_TYPE_RISE, DALU_TYPE_EDGE, DALU_TYPE_HIGH};
			`CHK("rise", e_b | (t == DALU_TYPE_LOW), alarm_active[1])
			`CHK("out0", e_b | (t == DALU_TYPE_LOW), out_active[0])
			pin(1, 1'b0);
			`CHK("fall", t != DALU_TYPE_NONE, alarm_active[1])
			ack(1);
			`CHK("early ack", t == DALU_TYPE_LOW, alarm_active[1])
			pin(1, 1'b1);
			`CHK("recorded", e_b, alarm_active[1])
		end
		// --------------------------------
		// Indication, relay, manual mode
		// --------------------------------
		do_rst({15'h0, 5'h10, 5'h0, 5'h12, 10'h0});
		pin(4, 1'b1);
		`CHK("alone", 8'h10, alarm_active)
		`CHK("relay", 8'hef, relay_drive_n)
		beacon();
		`CHK("flash", 1'b1, b_or & ~b_and)
		ack(4);
		`CHK("acked", 1'b1, alarm_acked[4])
		beacon();
		`CHK("steady", 1'b1, b_and & alarm_active[4])
		`CHK("relay held", 8'hef, relay_drive_n)
		pin(4, 1'b0);
		`CHK("clear", 8'h00, alarm_active)
		`CHK("relay off", 8'hff, relay_drive_n)
		beacon();
		`CHK("dark", 1'b0, b_or)
		pin(4, 1'b1);
		pin(4, 1'b0);
		`CHK("no ack", 8'h00, alarm_active)
		`CHK("relay kept", 8'hef, relay_drive_n)
		ack(4);
		`CHK("relay back", 8'hff, relay_drive_n)
		pin(2, 1'b1);
		ack(2);
		pin(2, 1'b0);
		`CHK("manual hold", 1'b1, alarm_active[2])
		ack(2);
		`CHK("manual clr", 1'b0, alarm_active[2])
		end_of_test();
	end
endmodule : dalu_top_test
`default_nettype wire
